//--- host_port_defs.svh
// timing constants for the dual-port ram host port controller
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

`define CLK_PERIOD_NS 10
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define ADDR_WIDTH 11
`define DATA_WIDTH 8
`define LEFT_MAILBOX_ADDR 11'h7fe
`define RIGHT_MAILBOX_ADDR 11'h7ff

`define T_ACCESS_NS 25
`define T_HIGHZ_NS 12
`define T_WP_NS 20
`define T_WZ_NS 15
`define T_DW_NS 12
`define T_WRITE_HOLD_NS 12
`define T_BDD_NS 30

`define ACCESS_CYC `CYC_MIN(`T_ACCESS_NS)
`define HIGHZ_CYC `CYC_MIN(`T_HIGHZ_NS)
`define PULSE_CYC `CYC_MIN((`T_WP_NS > (`T_WZ_NS + `T_DW_NS)) ? `T_WP_NS : (`T_WZ_NS + `T_DW_NS))
`define WRITE_HOLD_CYC `CYC_MIN(`T_WRITE_HOLD_NS)
`define BDD_CYC `CYC_MIN(`T_BDD_NS)

`endif

//--- host_port_pkg.sv
// types for the dual-port ram host port controller
package host_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_PULSE,
      ST_WAIT_BLOCK,
      ST_HOLD,
      ST_READ,
      ST_SETTLE,
      ST_END
   } state_t;
endpackage

//--- pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;
endmodule
`default_nettype wire

//--- host_port_ctrl.sv
// host-side controller driving one port of an asynchronous dual-port ram
// ----------------------------------------------------------------------
// Functional notes
// (RQ1) host keeps chip select or write strobe high while address changes
// (RQ2) device writes only while chip select and write strobe both low
// (RQ3) chip select falling at or after write strobe keeps outputs floating
// (RQ4) write pulse lasts the larger of minimum pulse or float plus set-up
// (RQ5) host drives no write data while device may still drive the pins
// (RQ6) read data valid after all access delays and blocked-release delay
// (RQ7) chip select high deselects port and floats its data pins
// (RQ8) chip select and write strobe low store the byte
// (RQ9) chip select low, strobe high: output enable low drives read data
// (RQ10) blocked low discards writes; read data may be invalid
// (RQ11) left write to 7ff sets right flag; right read of 7ff clears it
// (RQ12) right write to 7fe sets left flag; left read of 7fe clears it
// (RQ13) blocked port access leaves interrupt flags unchanged
// (RQ14) earlier port by arbitration set-up wins; otherwise either blocked
// (RQ15) loser's blocked low gates its write strobe until release
// (RQ16) blocked host holds write at least write-hold time after release
// (RQ17) written data reaches other port within write-to-data delay
// (RQ18) blocked-release delay is max of zero and the two residual delays
// (RQ19) arbitration looks only at chip selects and addresses
// (RQ20) both blocked indications never low together
// (RQ21) mailbox words are ordinary memory bytes
// (RQ22) differing addresses or a deselected port keep both unblocked
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"
module host_port_ctrl #(
   parameter int AW = `ADDR_WIDTH,
   parameter int DW = `DATA_WIDTH
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [AW-1:0] REQ_ADDR,
   input wire logic [DW-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_DONE,
   output logic [DW-1:0] RSP_RDATA,
   output logic RSP_WAS_BLOCKED,
   output logic MAIL_PENDING,
   output logic CE_N,
   output logic RW_N,
   output logic OE_N,
   output logic [AW-1:0] ADDR,
   output logic [DW-1:0] DATA_O,
   output logic DATA_OE,
   input wire logic [DW-1:0] DATA_I,
   input wire logic BLOCKED_N,
   input wire logic MAIL_FLAG_N
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [DW+1:0] pins_s;
   logic blocked_s;
   logic mail_s;
   logic [DW-1:0] data_s;

   pin_sync #(.WIDTH(DW + 2), .RESET_VAL({2'b11, {DW{1'b0}}})) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .din({BLOCKED_N, MAIL_FLAG_N, DATA_I}),
      .dout(pins_s)
   );
   assign blocked_s = pins_s[DW+1];
   assign mail_s = pins_s[DW];
   assign data_s = pins_s[DW-1:0];

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   host_port_pkg::state_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic ce_n_ff, nxt_ce_n;
   logic rw_n_ff, nxt_rw_n;
   logic oe_n_ff, nxt_oe_n;
   logic data_oe_ff, nxt_data_oe;
   logic [AW-1:0] addr_ff, nxt_addr;
   logic [DW-1:0] wdata_ff, nxt_wdata;
   logic [DW-1:0] rdata_ff, nxt_rdata;
   logic done_ff, nxt_done;
   logic blk_seen_ff, nxt_blk_seen;

   function automatic logic [3:0] cyc4(input int n);
      cyc4 = n[3:0];
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ce_n = ce_n_ff;
      nxt_rw_n = rw_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_data_oe = data_oe_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_rdata = rdata_ff;
      nxt_done = 1'b0;
      nxt_blk_seen = blk_seen_ff;
      unique case (state_ff)
         host_port_pkg::ST_IDLE: begin
            if (REQ_VALID) begin
               // address moves only while chip select is high
               nxt_addr = REQ_ADDR; // RQ1
               nxt_wdata = REQ_WDATA;
               nxt_ce_n = 1'b0;
               nxt_blk_seen = 1'b0;
               if (REQ_WRITE) begin
                  nxt_oe_n = 1'b1;
                  nxt_cnt = cyc4(`HIGHZ_CYC);
                  nxt_state = host_port_pkg::ST_SETUP;
               end else begin
                  nxt_oe_n = 1'b0;
                  nxt_cnt = cyc4(`ACCESS_CYC);
                  nxt_state = host_port_pkg::ST_READ;
               end
            end
         end
         host_port_pkg::ST_SETUP: begin
            // output enable high long enough for the device to float
            if (cnt_ff == 4'h1) begin
               nxt_rw_n = 1'b0;
               nxt_data_oe = 1'b1; // RQ5
               nxt_cnt = cyc4(`PULSE_CYC); // RQ4
               nxt_state = host_port_pkg::ST_PULSE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         host_port_pkg::ST_PULSE: begin
            if (!blocked_s) begin
               // device gates our strobe; keep it low until release
               nxt_blk_seen = 1'b1;
               nxt_state = host_port_pkg::ST_WAIT_BLOCK; // RQ15
            end else if (cnt_ff == 4'h1) begin
               nxt_state = host_port_pkg::ST_END;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         host_port_pkg::ST_WAIT_BLOCK: begin
            if (blocked_s) begin
               nxt_cnt = cyc4(`WRITE_HOLD_CYC); // RQ16
               nxt_state = host_port_pkg::ST_HOLD;
            end
         end
         host_port_pkg::ST_HOLD: begin
            if (cnt_ff == 4'h1) begin
               nxt_state = host_port_pkg::ST_END;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         host_port_pkg::ST_READ: begin
            if (!blocked_s) begin
               nxt_blk_seen = 1'b1;
               // release delay plus the two flops in front of the data bus
               nxt_cnt = cyc4(`BDD_CYC + 2);
               nxt_state = host_port_pkg::ST_SETTLE; // RQ6
            end else if (cnt_ff == 4'h1) begin
               nxt_cnt = 4'h2;
               nxt_state = host_port_pkg::ST_SETTLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         host_port_pkg::ST_SETTLE: begin
            // covers the two-flop latency of the data synchroniser too
            if (!blocked_s) begin
               // restart from the synced release, so data is sampled past the delay
               nxt_cnt = cyc4(`BDD_CYC + 2); // RQ18
            end else if (cnt_ff == 4'h1) begin
               nxt_rdata = data_s;
               nxt_state = host_port_pkg::ST_END;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         host_port_pkg::ST_END: begin
            nxt_rw_n = 1'b1;
            nxt_ce_n = 1'b1;
            nxt_oe_n = 1'b1;
            nxt_data_oe = 1'b0;
            nxt_done = 1'b1;
            nxt_state = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_ff <= host_port_pkg::ST_IDLE;
         cnt_ff <= 4'h0;
         ce_n_ff <= 1'b1;
         rw_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         data_oe_ff <= 1'b0;
         addr_ff <= '0;
         wdata_ff <= '0;
         rdata_ff <= '0;
         done_ff <= 1'b0;
         blk_seen_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ce_n_ff <= nxt_ce_n;
         rw_n_ff <= nxt_rw_n;
         oe_n_ff <= nxt_oe_n;
         data_oe_ff <= nxt_data_oe;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         rdata_ff <= nxt_rdata;
         done_ff <= nxt_done;
         blk_seen_ff <= nxt_blk_seen;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign REQ_READY = (state_ff == host_port_pkg::ST_IDLE);
   assign RSP_DONE = done_ff;
   assign RSP_RDATA = rdata_ff;
   assign RSP_WAS_BLOCKED = blk_seen_ff;
   assign MAIL_PENDING = ~mail_s;
   assign CE_N = ce_n_ff;
   assign RW_N = rw_n_ff;
   assign OE_N = oe_n_ff;
   assign ADDR = addr_ff;
   assign DATA_O = wdata_ff;
   assign DATA_OE = data_oe_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_addr_quiet;
      @(posedge CORE_CLK) disable iff (RST)
      !$stable(addr_ff) |-> ($past(ce_n_ff) && rw_n_ff);
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) // RQ1
      else $error("address changed while selected for write");

   property p_pulse_len;
      @(posedge CORE_CLK) disable iff (RST)
      $fell(rw_n_ff) |-> !rw_n_ff [*3];
   endproperty
   a_pulse_len: assert property (p_pulse_len) // RQ4
      else $error("write pulse shorter than three cycles");

   property p_no_drive_clash;
      @(posedge CORE_CLK) disable iff (RST)
      $rose(data_oe_ff) |-> $past(oe_n_ff, 1) && $past(oe_n_ff, 2) && !rw_n_ff;
   endproperty
   a_no_drive_clash: assert property (p_no_drive_clash) // RQ5
      else $error("write data driven before device floated");

   property p_hold_after_block;
      @(posedge CORE_CLK) disable iff (RST)
      (state_ff == host_port_pkg::ST_WAIT_BLOCK && blocked_s) |=>
         !rw_n_ff [*3] ##1 rw_n_ff;
   endproperty
   a_hold_after_block: assert property (p_hold_after_block) // RQ16
      else $error("write not held for hold time after release");
endmodule
`default_nettype wire

//--- dpram_model.sv
// behavioural dual-port ram, left port faces the controller
`timescale 1ns/1ps
`default_nettype none
module dpram_model (
   input wire logic l_ce_n,
   input wire logic l_rw_n,
   input wire logic l_oe_n,
   input wire logic [10:0] l_addr,
   input wire logic [7:0] l_din,
   output logic [7:0] l_dq,
   output logic l_blk_n,
   output var logic l_flag_n,
   input wire logic r_ce_n,
   input wire logic r_rw_n,
   input wire logic r_oe_n,
   input wire logic [10:0] r_addr,
   input wire logic [7:0] r_din,
   output logic [7:0] r_dq,
   output logic r_blk_n,
   output var logic r_flag_n
);
   logic [7:0] mem [0:2047];
   logic lb, rb, l_wr, r_wr;
   logic [11:0] lp, rp;
   realtime lt, rt;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      lb = 0; rb = 0; l_flag_n = 1; r_flag_n = 1; lt = 0; rt = 0; lp = '1; rp = '1;
   end
   // ----
   // arbitration: the later arrival loses
   // ----
   always @(l_ce_n, l_addr, r_ce_n, r_addr) begin
      if ({l_ce_n, l_addr} !== lp) lt = $realtime;
      if ({r_ce_n, r_addr} !== rp) rt = $realtime;
      lp = {l_ce_n, l_addr};
      rp = {r_ce_n, r_addr};
      if (l_ce_n || r_ce_n || l_addr != r_addr) begin
         lb = 0;
         rb = 0;
      end else if (!lb && !rb) begin
         lb = lt > rt;
         rb = !(lt > rt);
      end
   end
   assign l_blk_n = !lb;
   assign r_blk_n = !rb;
   assign l_wr = !l_ce_n && !l_rw_n && !lb;
   assign r_wr = !r_ce_n && !r_rw_n && !rb;
   always @* begin
      if (l_wr) mem[l_addr] = l_din;
      if (r_wr) mem[r_addr] = r_din;
      if (l_wr && l_addr == 11'h7ff) r_flag_n = 0;
      if (r_wr && r_addr == 11'h7fe) l_flag_n = 0;
      if (!r_ce_n && !r_oe_n && !rb && r_addr == 11'h7ff) r_flag_n = 1;
      if (!l_ce_n && !l_oe_n && !lb && l_addr == 11'h7fe) l_flag_n = 1;
   end
   // floating pins show the complement so a stale byte never passes
   assign #25 l_dq = (!l_ce_n && l_rw_n && !l_oe_n && !lb) ? mem[l_addr] : ~mem[l_addr];
   assign #25 r_dq = (!r_ce_n && r_rw_n && !r_oe_n && !rb) ? mem[r_addr] : ~mem[r_addr];
endmodule
`default_nettype wire

//--- host_port_ctrl_tb.sv
// self-checking bench for the host port controller against a ram model
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.svh"
module host_port_ctrl_tb;
   logic clk, rst, valid, wr, ready, done, wasb, pend, ce_n, rw_n, oe_n, doe, blk_n, flag_n;
   logic rce_n, rrw_n, roe_n, rblk_n, rflag_n;
   logic [10:0] a, addr, ra;
   logic [7:0] wd, rdata, dout, din, rdin, rdq, rv;
   int err_total, n_tests, cyc;
   host_port_ctrl dut_u (.CORE_CLK(clk), .RST(rst), .REQ_VALID(valid), .REQ_WRITE(wr),
      .REQ_ADDR(a), .REQ_WDATA(wd), .REQ_READY(ready), .RSP_DONE(done), .RSP_RDATA(rdata),
      .RSP_WAS_BLOCKED(wasb), .MAIL_PENDING(pend), .CE_N(ce_n), .RW_N(rw_n), .OE_N(oe_n),
      .ADDR(addr), .DATA_O(dout), .DATA_OE(doe), .DATA_I(din), .BLOCKED_N(blk_n),
      .MAIL_FLAG_N(flag_n));
   dpram_model ram_u (.l_ce_n(ce_n), .l_rw_n(rw_n), .l_oe_n(oe_n), .l_addr(addr),
      .l_din(doe ? dout : ~dout), .l_dq(din), .l_blk_n(blk_n), .l_flag_n(flag_n),
      .r_ce_n(rce_n), .r_rw_n(rrw_n), .r_oe_n(roe_n), .r_addr(ra), .r_din(rdin), .r_dq(rdq),
      .r_blk_n(rblk_n), .r_flag_n(rflag_n));
   // ----
   // shared tasks
   // ----
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic go(input logic w, input logic [10:0] ad, input logic [7:0] d);
      @(negedge clk);
      valid = 1; wr = w; a = ad; wd = d;
      // ready is looked at between edges; the next rising edge takes the request
      while (ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      valid = 0;
      cyc = 0;
   endtask
   task automatic fin;
      while (done !== 1'b1 && cyc < 300) begin
         @(negedge clk);
         cyc++;
      end
      check("done", 1, done);
   endtask
   // far port moves its address only while deselected and keeps it steady while selected
   task automatic racc(input logic w, input logic [10:0] ad, input logic [7:0] d);
      @(negedge clk);
      ra = ad; rdin = d;
      @(negedge clk);
      rce_n = 0; rrw_n = !w; roe_n = w;
      repeat (4) @(negedge clk);
      rv = rdq;
      rce_n = 1; rrw_n = 1; roe_n = 1;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      check("idle pins", 7'b1110100, {ce_n, rw_n, oe_n, doe, ready, done, pend});
      $display("t_reset over");
   endtask
   task automatic t_wr_rd;
      go(1, 11'h123, 8'ha5);
      fin;
      check("write latency", `HIGHZ_CYC + `PULSE_CYC + 1, cyc);
      check("no block", 0, wasb);
      go(0, 11'h123, 8'h00);
      fin;
      check("own read", 8'ha5, rdata);
      racc(0, 11'h123, 8'h00);
      check("far read", 8'ha5, rv);
      racc(1, 11'h000, 8'h3c);
      go(0, 11'h000, 8'h00);
      fin;
      check("far written", 8'h3c, rdata);
      $display("t_wr_rd over");
   endtask
   task automatic t_mail;
      go(1, 11'h7ff, 8'h81);
      fin;
      check("far flag set", 0, rflag_n);
      racc(0, 11'h7ff, 8'h00);
      check("far mailbox byte", 8'h81, rv);
      check("far flag clear", 1, rflag_n);
      racc(1, 11'h7fe, 8'h42);
      repeat (4) @(negedge clk);
      check("mail pending", 1, pend);
      go(0, 11'h7fe, 8'h00);
      fin;
      check("mailbox byte", 8'h42, rdata);
      repeat (4) @(negedge clk);
      check("mail cleared", 0, pend);
      $display("t_mail over");
   endtask
   task automatic t_block;
      racc(1, 11'h055, 8'h11);
      @(negedge clk);
      rce_n = 0; roe_n = 0;
      go(1, 11'h055, 8'hee);
      repeat (10) @(negedge clk);
      check("done while blocked", 0, done);
      check("block sides", 2'b01, {blk_n, rblk_n});
      check("strobe held", 0, rw_n);
      check("write discarded", 8'h11, rdq);
      rce_n = 1; roe_n = 1;
      fin;
      check("blocked seen", 1, wasb);
      racc(0, 11'h055, 8'h00);
      check("late write", 8'hee, rv);
      // far port writing while we read the same byte: our read must wait
      @(negedge clk);
      ra = 11'h066; rdin = 8'h5a;
      @(negedge clk);
      rce_n = 0; rrw_n = 0;
      go(0, 11'h066, 8'h00);
      repeat (8) @(negedge clk);
      check("read held while blocked", 0, done);
      check("read block sides", 2'b01, {blk_n, rblk_n});
      rdin = 8'hc3;
      @(negedge clk);
      rce_n = 1; rrw_n = 1;
      fin;
      check("read after release", 8'hc3, rdata);
      check("read blocked seen", 1, wasb);
      $display("t_block over");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst = 1; valid = 0; wr = 0; a = 0; wd = 0; ra = 0; rdin = 0; rv = 0;
      rce_n = 1; rrw_n = 1; roe_n = 1; err_total = 0; n_tests = 0; cyc = 0;
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst = 0;
      t_reset;
      t_wr_rd;
      t_mail;
      t_block;
      results;
   end
   // the tests need well under 1000 cycles, so 20000 means a hang
   initial begin
      #200000;
      err_total++;
      results;
   end
endmodule
`default_nettype wire
